// >>> hdl/sys_if_mode_pkg.sv
// shared constants for the system interface mode control block
package sys_if_mode_pkg;
  localparam logic [11:0] SYS_IF_MODE_REG0_OFFSET = 12'h100;
  localparam logic [7:0] SYS_IF_MODE_RESET = 8'h00;
  localparam int TEST_MODE_BIT = 0;
  localparam int FAST_CLK_BIT = 1;
  localparam int SOFT_RESET_BIT = 2;
  localparam int FLOW_PARITY_BIT = 3;
  localparam int BYTE_ORDER_BIT = 4;
  localparam int VIRTUAL_ADDRESSING_SEL_ADDR_BIT = 5;
  localparam int SMALL_QUEUE_BIT = 6;
  localparam int SHORT_BURST_BIT = 7;
  localparam logic [7:0] LOSS_LIMIT_NORMAL = 8'hFF;
  localparam logic [7:0] LOSS_LIMIT_TEST = 8'h04;
  localparam int SOFT_RESET_CYCLES = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] QUEUE_SIZE_LOG_KB_BIG = 3'h2;
  localparam logic [2:0] QUEUE_SIZE_LOG_KB_SMALL = 3'h0;
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_BUSY = 2'b01,
    SR_DONE = 2'b10
  } soft_reset_state_t;
endpackage

// >>> hdl/system_interface_mode_control.sv
// mode register, soft reset sequencer and parity paths of the system if
//
// Function
// - every mode bit reads zero after any device reset.
// - test bit shortens the service-loss frame limit from 255 to four.
// - fast clock bit only trims synchronizer timing; leave it at zero.
// - soft reset stops indicate, request, status machines and resets regs.
// - soft reset bit clears itself once the reset sequence completes.
// - flow parity bit enables parity checks on indicate receive data.
// - all generated and checked parity is odd parity per byte.
// - receive parity error sets one flag, descriptor error another.
// - host bus receive bytes are never parity checked.
// - with flow parity, host parity bits travel to transmit request side.
// - parity driven onto the host bus is always correct.
// - without flow parity, transmit request parity is freshly generated.
// - receive checks cover every byte from frame control to end delimiter.
// - without flow parity no indicate data parity checking happens.
// - control bus parity follows its own enable, not the flow bit.
// - byte order bit selects little endian at zero, big endian at one.
// - virtual addressing bit selects virtual at one, physical at zero.
// - small queue bit sizes descriptor queues 4 kB or 1 kB.
// - short burst bit limits bursts to 1 and 4 words when set.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module system_interface_mode_control
  import sys_if_mode_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // axi4-lite write address and data
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame counter and service loss
  input wire logic frame_transmitted,
  input wire logic counter_clear,
  output logic service_loss,
  // mode outputs to the rest of the system interface
  output logic fast_host_bus_clock_sel,
  output logic byte_order_select,
  output logic virtual_addressing_sel,
  output logic small_queue_sel,
  output logic [2:0] queue_size_log_kb,
  output logic short_burst_sel,
  output logic eight_word_burst_ok,
  output logic machines_stop,
  output logic sys_if_regs_init,
  // host bus to transmit request path
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_byte,
  input wire logic host_rx_parity,
  output logic tx_req_valid,
  output logic [7:0] tx_req_byte,
  output logic tx_req_parity,
  // data driven onto the host bus
  input wire logic [7:0] host_tx_byte,
  output logic host_tx_parity,
  // indicate receive data
  input wire logic ind_valid,
  input wire logic ind_in_frame,
  input wire logic [7:0] ind_byte,
  input wire logic ind_parity,
  // descriptor fetch
  input wire logic desc_valid,
  input wire logic [31:0] desc_word,
  input wire logic [3:0] desc_parity,
  // control bus
  input wire logic control_bus_parity_enable,
  input wire logic cbus_valid,
  input wire logic [7:0] cbus_byte,
  input wire logic cbus_parity,
  output logic cbus_parity_error,
  // status flags and their clears
  input wire logic status_clear_rx,
  input wire logic status_clear_err,
  output logic receive_parity_error_flag,
  output logic general_error_flag
);

  // the map decode slices the 12 bit offset, so wider buses cannot be served
  if (ADDR_WIDTH < 9 || ADDR_WIDTH > 12) begin : addr_width_check_g
    $error("address width outside the register map");
  end

  // odd parity: bit makes the total count of ones odd
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction

  logic [7:0] sys_if_mode_reg0_q;
  soft_reset_state_t sr_state_q;
  logic [2:0] sr_count_q;
  logic [7:0] frame_count_q;
  logic [ADDR_WIDTH-1:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic wr_hit;
  logic rd_fire;

  // one write and one read in flight; address and data taken in any order
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_hit = (aw_addr_q[ADDR_WIDTH-1:2] ==
    SYS_IF_MODE_REG0_OFFSET[ADDR_WIDTH-1:2]);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // write address capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read response; upper 24 bits read zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      if (s_axi_araddr[ADDR_WIDTH-1:2] ==
          SYS_IF_MODE_REG0_OFFSET[ADDR_WIDTH-1:2]) begin
        rdata_q <= {24'h00_0000, sys_if_mode_reg0_q};
        rresp_q <= RESP_OKAY;
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // mode register; soft reset zeroes it except the pending reset bit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sys_if_mode_reg0_q <= SYS_IF_MODE_RESET;
    end else if (sr_state_q == SR_DONE) begin
      sys_if_mode_reg0_q <= SYS_IF_MODE_RESET;
    end else if (sr_state_q == SR_BUSY) begin
      sys_if_mode_reg0_q <= SYS_IF_MODE_RESET | 8'h04;
    end else if (wr_fire & wr_hit & w_strb_q[0]) begin
      sys_if_mode_reg0_q <= w_data_q[7:0];
    end
  end

  // soft reset sequencer, held long enough for all machines to stop
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sr_state_q <= SR_IDLE;
      sr_count_q <= 3'h0;
    end else begin
      case (sr_state_q)
        SR_IDLE: begin
          sr_count_q <= 3'h0;
          if (sys_if_mode_reg0_q[SOFT_RESET_BIT]) begin
            sr_state_q <= SR_BUSY;
          end
        end
        SR_BUSY: begin
          sr_count_q <= sr_count_q + 3'h1;
          if (sr_count_q == 3'(SOFT_RESET_CYCLES - 1)) begin
            sr_state_q <= SR_DONE;
          end
        end
        SR_DONE: begin
          sr_state_q <= SR_IDLE;
        end
        default: begin
          sr_state_q <= SR_IDLE;
        end
      endcase
    end
  end

  // stop stays up for the whole sequence so no machine restarts early
  assign machines_stop = (sr_state_q != SR_IDLE) |
    sys_if_mode_reg0_q[SOFT_RESET_BIT];
  assign sys_if_regs_init = (sr_state_q == SR_BUSY);

  // mode decode; fast clock bit only passed on, software owns its legality
  assign fast_host_bus_clock_sel = sys_if_mode_reg0_q[FAST_CLK_BIT];
  assign byte_order_select = sys_if_mode_reg0_q[BYTE_ORDER_BIT];
  assign virtual_addressing_sel = sys_if_mode_reg0_q[VIRTUAL_ADDRESSING_SEL_ADDR_BIT];
  assign small_queue_sel = sys_if_mode_reg0_q[SMALL_QUEUE_BIT];
  assign queue_size_log_kb = small_queue_sel ? QUEUE_SIZE_LOG_KB_SMALL :
    QUEUE_SIZE_LOG_KB_BIG;
  assign short_burst_sel = sys_if_mode_reg0_q[SHORT_BURST_BIT];
  assign eight_word_burst_ok = ~short_burst_sel;

  // transmitted frame counter with selectable service-loss limit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_count_q <= 8'h00;
    end else if (counter_clear | sys_if_regs_init) begin
      frame_count_q <= 8'h00;
    end else if (frame_transmitted & ~service_loss) begin
      frame_count_q <= frame_count_q + 8'h01;
    end
  end
  assign service_loss = frame_count_q >= (sys_if_mode_reg0_q[TEST_MODE_BIT] ?
    LOSS_LIMIT_TEST : LOSS_LIMIT_NORMAL);

  // transmit request path; host byte itself never checked
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_req_valid <= 1'b0;
      tx_req_byte <= 8'h00;
      tx_req_parity <= 1'b1;
    end else begin
      tx_req_valid <= host_rx_valid;
      if (host_rx_valid) begin
        tx_req_byte <= host_rx_byte;
        // forwarding lets the ring engine catch corruption end to end
        tx_req_parity <= sys_if_mode_reg0_q[FLOW_PARITY_BIT] ?
          host_rx_parity : odd_par(host_rx_byte);
      end
    end
  end

  // parity on host bus output always regenerated
  assign host_tx_parity = odd_par(host_tx_byte);

  logic ind_err;
  logic desc_err;
  logic cbus_err;
  // indicate checks span fc through ed while in frame
  assign ind_err = sys_if_mode_reg0_q[FLOW_PARITY_BIT] & ind_valid &
    ind_in_frame & (odd_par(ind_byte) != ind_parity);
  assign desc_err = desc_valid &
    ((odd_par(desc_word[7:0]) != desc_parity[0]) |
     (odd_par(desc_word[15:8]) != desc_parity[1]) |
     (odd_par(desc_word[23:16]) != desc_parity[2]) |
     (odd_par(desc_word[31:24]) != desc_parity[3]));
  assign cbus_err = control_bus_parity_enable & cbus_valid &
    (odd_par(cbus_byte) != cbus_parity);

  // sticky rx and general flags, cbus flag follows each cycle; a new error wins over a clear in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      receive_parity_error_flag <= 1'b0;
    end else if (ind_err) begin
      receive_parity_error_flag <= 1'b1;
    end else if (status_clear_rx | sys_if_regs_init) begin
      receive_parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      general_error_flag <= 1'b0;
    end else if (desc_err) begin
      general_error_flag <= 1'b1;
    end else if (status_clear_err | sys_if_regs_init) begin
      general_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cbus_parity_error <= 1'b0;
    end else begin
      cbus_parity_error <= cbus_err;
    end
  end

endmodule

// >>> verif/sys_if_mode_monitor.sv
// assertion checker bound to the system interface mode control block
`timescale 1ns/1ps
module sys_if_mode_monitor (
  // clock and reset
  input wire logic clock, sys_rst,
  // byte paths and parity
  input wire logic [7:0] host_tx_byte, host_rx_byte, tx_req_byte, cbus_byte,
  input wire logic host_tx_parity, host_rx_valid, tx_req_valid, cbus_valid,
  input wire logic cbus_parity, control_bus_parity_enable, cbus_parity_error,
  input wire logic desc_valid, general_error_flag, receive_parity_error_flag,
  input wire logic [31:0] desc_word,
  input wire logic [3:0] desc_parity,
  // mode outputs and soft reset
  input wire logic small_queue_sel, short_burst_sel, eight_word_burst_ok,
  input wire logic [2:0] queue_size_log_kb,
  input wire logic sys_if_regs_init
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // each ties an output to its cause; error flags land one edge late
  host_par_a: assert property (host_tx_parity == ~^host_tx_byte)
    else $error("host parity even");
  tx_fwd_a: assert property (host_rx_valid |=> tx_req_valid &&
    tx_req_byte == $past(host_rx_byte)) else $error("byte not forwarded");
  queue_size_a: assert property (queue_size_log_kb ==
    (small_queue_sel ? 3'h0 : 3'h2)) else $error("queue size wrong");
  burst_sel_a: assert property (eight_word_burst_ok != short_burst_sel)
    else $error("burst select wrong");
  cbus_err_a: assert property (control_bus_parity_enable && cbus_valid &&
    cbus_parity == ^cbus_byte |=> cbus_parity_error) else $error("cbus miss");
  cbus_quiet_a: assert property (!control_bus_parity_enable |=>
    !cbus_parity_error) else $error("cbus error while disabled");
  desc_err_a: assert property (desc_valid &&
    desc_parity[0] == ^desc_word[7:0] |=> general_error_flag) else $error("desc");
  soft_len_a: assert property ($rose(sys_if_regs_init) |->
    sys_if_regs_init [*4] ##1 !sys_if_regs_init) else $error("reset length");
  // main scenarios reached
  cover property ($rose(sys_if_regs_init));
  cover property ($rose(receive_parity_error_flag));
  cover property ($rose(cbus_parity_error));
endmodule
bind system_interface_mode_control sys_if_mode_monitor monitor (.*);

// >>> verif/host_bus_model.sv
// host bus side model: bytes with byte parity toward the transmit path
`timescale 1ns/1ps
module host_bus_model (
  // clock and bench requests
  input wire logic clock, send, bad,
  input wire logic [7:0] data,
  // host bus byte lane
  output logic host_rx_valid, host_rx_parity,
  output logic [7:0] host_rx_byte
);
  logic [7:0] last_q = 8'hA5;
  // idle lane shows the inverse of the last byte, never a stale copy
  always @(posedge clock) if (send) last_q <= data;
  assign host_rx_valid = send;
  assign host_rx_byte = send ? data : ~last_q;
  assign host_rx_parity = send ? ~^data ^ bad : ^last_q;
endmodule

// >>> verif/system_interface_mode_control_test.sv
// self-checking bench for the system interface mode control block
`timescale 1ns/1ps
module system_interface_mode_control_test;
  import sys_if_mode_pkg::*;
  // bench-driven design inputs
  logic clock = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, bad = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, ind_valid = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic frame_transmitted = 0, counter_clear = 0, ind_in_frame = 0;
  logic ind_parity = 0, control_bus_parity_enable = 0;
  logic [7:0] ind_byte = 0, v;
  // side streams share one byte so one expectation covers them all
  wire [7:0] host_tx_byte = ind_byte, cbus_byte = ind_byte;
  wire [31:0] desc_word = {4{ind_byte}};
  wire [3:0] desc_parity = {{3{~^ind_byte}}, ind_parity};
  wire desc_valid = ind_valid, cbus_valid = ind_valid, cbus_parity = ind_parity;
  wire status_clear_rx = counter_clear, status_clear_err = counter_clear;
  // design outputs and bench state
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic service_loss, fast_host_bus_clock_sel, byte_order_select;
  logic virtual_addressing_sel, small_queue_sel, short_burst_sel;
  logic eight_word_burst_ok, machines_stop, sys_if_regs_init, tx_req_valid;
  logic tx_req_parity, host_rx_valid, host_rx_parity, host_tx_parity;
  logic cbus_parity_error, receive_parity_error_flag, general_error_flag;
  logic [2:0] queue_size_log_kb;
  logic [7:0] tx_req_byte, host_rx_byte;
  logic go_a, go_w, go_r, got, exp_rx, exp_err;
  int fails = 0, cmp_count = 0, cyc = 0, seed = 32'hcb3921ae, n;
  system_interface_mode_control DUT (.*);
  host_bus_model host (.clock(clock), .send(ind_valid), .bad(bad),
    .data(ind_byte), .host_rx_valid(host_rx_valid),
    .host_rx_parity(host_rx_parity), .host_rx_byte(host_rx_byte));
  always #10 clock = ~clock;
  // hang guard, the run needs far fewer cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict;
    end
  end
  task chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("unexpected at %0t: %h not %h", $time, seen, exp);
  endtask
  task print_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function logic odd(input logic [7:0] b);
    return ~^b;
  endfunction
  // expected mode outputs: four select bits, eight-word burst, queue size
  function logic [7:0] mode_exp(input logic [7:0] m);
    return {m[7:4], ~m[7], m[6] ? 3'h0 : 3'h2};
  endfunction
  // one bus transfer; ready sampled at negedge is the value at the next edge
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(negedge clock);
      {go_a, go_w, go_r} = {s_axi_awready, s_axi_wready, s_axi_arready};
      got = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rd_data = s_axi_rdata;
      @(posedge clock);
      if (go_a) s_axi_awvalid <= 0;
      if (go_w) s_axi_wvalid <= 0;
      if (go_r) s_axi_arvalid <= 0;
    end while (!got);
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    // idle edge so a following call never re-drives a signal in one step
    @(posedge clock);
  endtask
  task clr;
    counter_clear <= 1;
    @(posedge clock);
    counter_clear <= 0;
  endtask
  task frames(input int cnt, lim);
    for (int i = 0; i < cnt; i++) begin
      frame_transmitted <= 1;
      @(posedge clock);
      frame_transmitted <= 0;
      @(negedge clock);
      chk(service_loss, i + 1 >= lim);
      @(posedge clock);
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    bus(0, 12'h104, 0);
    chk(rsp, RESP_SLVERR);
    bus(0, SYS_IF_MODE_REG0_OFFSET, 0);
    chk(rd_data, SYS_IF_MODE_RESET);
    // random modes; fast clock and soft reset bits stay clear
    for (int k = 0; k < 5; k++) begin
      v = k == 4 ? 8'hF9 : 8'($random(seed)) & 8'hF9;
      bus(1, SYS_IF_MODE_REG0_OFFSET, v);
      bus(0, SYS_IF_MODE_REG0_OFFSET, 0);
      chk(rd_data, v);
      chk(fast_host_bus_clock_sel, v[1]);
      chk({short_burst_sel, small_queue_sel, virtual_addressing_sel,
        byte_order_select, eight_word_burst_ok, queue_size_log_kb},
        mode_exp(v));
    end
    bus(1, SYS_IF_MODE_REG0_OFFSET, 8'h08);
    clr;
    frames(255, 255);
    bus(1, SYS_IF_MODE_REG0_OFFSET, 8'h09);
    clr;
    frames(5, 4);
    // parity paths with flow off, then on, with random faults
    for (int f = 0; f < 2; f++) begin
      bus(1, SYS_IF_MODE_REG0_OFFSET, f ? 8'h08 : 8'h00);
      clr;
      exp_rx = 0;
      exp_err = 0;
      // 64 clean in-frame bytes with flow parity on must leave both error flags low
      if (f) begin
        ind_valid <= 1;
        ind_in_frame <= 1;
        bad <= 0;
        control_bus_parity_enable <= 0;
        for (int b = 0; b < 64; b++) begin
          ind_byte <= 8'(b);
          ind_parity <= odd(8'(b));
          @(posedge clock);
        end
        ind_valid <= 0;
        @(negedge clock);
        chk({receive_parity_error_flag, general_error_flag}, 0);
        chk(tx_req_byte, 8'h3F);
        @(posedge clock);
      end
      repeat (8) begin
        v = 8'($random(seed));
        n = $random(seed);
        ind_valid <= 1;
        ind_byte <= v;
        ind_in_frame <= n[1];
        ind_parity <= odd(v) ^ n[0];
        bad <= n[0];
        control_bus_parity_enable <= n[2];
        @(posedge clock);
        ind_valid <= 0;
        @(negedge clock);
        exp_rx |= f[0] & n[0] & n[1];
        exp_err |= n[0];
        chk(tx_req_parity, f ? odd(v) ^ n[0] : odd(v));
        chk({tx_req_valid, tx_req_byte}, {1'b1, v});
        chk(host_tx_parity, odd(v));
        chk(receive_parity_error_flag, exp_rx);
        chk(general_error_flag, exp_err);
        chk(cbus_parity_error, n[2] & n[0]);
        @(posedge clock);
      end
    end
    // soft reset must clear itself and wipe every mode bit; fast clock is written as zero here
    bus(1, SYS_IF_MODE_REG0_OFFSET, 8'hFD);
    @(negedge clock);
    chk(machines_stop, 1);
    @(posedge clock);
    n = 0;
    do begin
      bus(0, SYS_IF_MODE_REG0_OFFSET, 0);
      n++;
    end while (rd_data[2] && n < 20);
    chk(rd_data, 0);
    chk({receive_parity_error_flag, general_error_flag}, 0);
    chk(machines_stop, 0);
    // mode set up again directly after the soft reset, clocks are equal here
    bus(1, SYS_IF_MODE_REG0_OFFSET, 8'h42);
    bus(0, SYS_IF_MODE_REG0_OFFSET, 0);
    chk(rd_data, 8'h42);
    chk(fast_host_bus_clock_sel, 1);
    print_verdict;
  end
endmodule
